// ---- shared/ras_pkg.sv ----
// constants and register map of the return address stack
package ras_pkg;
   localparam int DEPTH = 16;
   localparam int WIDTH = 15;
   localparam int PTR_W = 5;
   localparam int LOW_W = 8;
   localparam int HIGH_W = 7;
   localparam logic [4:0] PTR_EMPTY = 5'h1f;
   localparam logic [4:0] PTR_LAST = 5'h0f;
   localparam logic [4:0] PTR_FIRST = 5'h00;
   localparam logic [4:0] PTR_RESET = 5'h1f;
   // byte offsets of the word registers
   localparam logic [7:0] OFF_POINTER = 8'h00;
   localparam logic [7:0] OFF_TOP_LOW = 8'h04;
   localparam logic [7:0] OFF_TOP_HIGH = 8'h08;
   localparam logic [7:0] OFF_CTRL = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   // field positions
   localparam int CTRL_FAULT_RST_EN = 0;
   localparam int STAT_OVF = 0;
   localparam int STAT_UNF = 1;
   localparam int STAT_W = 2;
   // values after reset
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [1:0] STAT_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
endpackage

// ---- hdl/ras_store.sv ----
// entry array of the return address stack, one write port, one read port
`timescale 1ns/1ns
`default_nettype none
module ras_store #(
   parameter int DEPTH = ras_pkg::DEPTH,
   parameter int WIDTH = ras_pkg::WIDTH,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wmask,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // no reset: contents after reset are undefined, as in the core
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
         if (we && waddr == AW'(i)) begin
            mem_q[i] <= (mem_q[i] & ~wmask) | (wdata & wmask);
         end
      end
   end

   assign rdata = mem_q[raddr];
endmodule // ras_store
`default_nettype wire

// ---- hdl/ras_top.sv ----
// return address stack with core push/pop port and ahb-lite registers
`timescale 1ns/1ns
`default_nettype none
module ras_top (
   input wire logic clk,
   input wire logic reset,
   // core sequencer side
   input wire logic core_push,
   input wire logic [14:0] core_push_pc,
   input wire logic core_pop,
   output logic [14:0] core_pop_pc,
   output logic fault_reset,
   output logic irq,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [4:0] stack_pointer_q;
   logic [4:0] stack_pointer_d;
   logic fault_rst_en_q;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] mask_q;
   logic fault_reset_q;
   logic wr_q;
   logic [7:0] waddr_q;
   logic [31:0] hrdata_q;
   logic [14:0] top_entry;

   logic push;
   logic pop;
   logic ovf;
   logic unf;
   logic fault;
   logic [4:0] push_ptr;
   logic [4:0] pop_ptr;
   logic acc;
   logic wr_ptr;
   logic wr_low;
   logic wr_high;
   logic mem_we;
   logic [3:0] mem_waddr;
   logic [14:0] mem_wmask;
   logic [14:0] mem_wdata;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // core push and pop

   // a simultaneous push and pop is not issued by the core; push wins
   assign push = core_push;
   assign pop = core_pop && !core_push;
   assign ovf = push && stack_pointer_q == ras_pkg::PTR_LAST;
   assign unf = pop && stack_pointer_q == ras_pkg::PTR_EMPTY;
   assign fault = (ovf || unf) && fault_rst_en_q;

   // last entry wraps to the first, empty wraps to the last
   assign push_ptr = (stack_pointer_q == ras_pkg::PTR_LAST) ? ras_pkg::PTR_FIRST
                     : stack_pointer_q + 5'h01;
   assign pop_ptr = (stack_pointer_q == ras_pkg::PTR_EMPTY) ? ras_pkg::PTR_LAST
                    : stack_pointer_q - 5'h01;

   // return address is read at the current pointer before it moves
   assign core_pop_pc = top_entry;

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states

   assign acc = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign wr_ptr = wr_q && waddr_q == ras_pkg::OFF_POINTER;
   assign wr_low = wr_q && waddr_q == ras_pkg::OFF_TOP_LOW;
   assign wr_high = wr_q && waddr_q == ras_pkg::OFF_TOP_HIGH;

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
      end else begin
         wr_q <= acc && hwrite;
         waddr_q <= haddr[7:0];
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         ras_pkg::OFF_POINTER: rd_mux[4:0] = stack_pointer_q;
         ras_pkg::OFF_TOP_LOW: rd_mux[7:0] = top_entry[7:0];
         ras_pkg::OFF_TOP_HIGH: rd_mux[6:0] = top_entry[14:8];
         ras_pkg::OFF_CTRL: rd_mux[ras_pkg::CTRL_FAULT_RST_EN] = fault_rst_en_q;
         ras_pkg::OFF_STATUS: rd_mux[1:0] = stat_q;
         ras_pkg::OFF_MASK: rd_mux[1:0] = mask_q;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data is sampled in the address phase; the master never overlaps
   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata_q <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         hrdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stack pointer

   always_comb begin
      stack_pointer_d = stack_pointer_q;
      if (fault) begin
         stack_pointer_d = ras_pkg::PTR_RESET;
      end else if (push) begin
         stack_pointer_d = push_ptr;
      end else if (pop) begin
         stack_pointer_d = pop_ptr;
      end else if (wr_ptr) begin
         // core moves take priority; a colliding software write is lost
         stack_pointer_d = hwdata[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         stack_pointer_q <= ras_pkg::PTR_RESET;
      end else begin
         stack_pointer_q <= stack_pointer_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // entry array

   // a push stores the pushed pc alone; the upper pc holding register has no path here
   always_comb begin
      mem_we = 1'b0;
      mem_waddr = stack_pointer_q[3:0];
      mem_wmask = 15'h0000;
      mem_wdata = 15'h0000;
      if (push && !fault) begin
         mem_we = 1'b1;
         mem_waddr = push_ptr[3:0];
         mem_wmask = 15'h7fff;
         mem_wdata = core_push_pc;
      end else if (!push && !pop && (wr_low || wr_high)) begin
         mem_we = 1'b1;
         mem_wmask = wr_low ? 15'h00ff : 15'h7f00;
         mem_wdata = {hwdata[6:0], hwdata[7:0]};
      end
   end

   ras_store #(
      .DEPTH(ras_pkg::DEPTH),
      .WIDTH(ras_pkg::WIDTH)
   ) u_store (
      .clk(clk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wmask(mem_wmask),
      .wdata(mem_wdata),
      .raddr(stack_pointer_q[3:0]),
      .rdata(top_entry)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control, flags, interrupt

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_rst_en_q <= ras_pkg::CTRL_RESET;
         mask_q <= ras_pkg::MASK_RESET;
      end else begin
         if (wr_q && waddr_q == ras_pkg::OFF_CTRL) begin
            fault_rst_en_q <= hwdata[ras_pkg::CTRL_FAULT_RST_EN];
         end
         if (wr_q && waddr_q == ras_pkg::OFF_MASK) begin
            mask_q <= hwdata[1:0];
         end
      end
   end

   // write one clears; a fault in the same cycle still sets
   always_comb begin
      stat_d = stat_q;
      if (wr_q && waddr_q == ras_pkg::OFF_STATUS) begin
         stat_d = stat_q & ~hwdata[1:0];
      end
      stat_d[ras_pkg::STAT_OVF] = stat_d[ras_pkg::STAT_OVF] | ovf;
      stat_d[ras_pkg::STAT_UNF] = stat_d[ras_pkg::STAT_UNF] | unf;
   end

   // flags survive the fault reset so software can find the cause
   always_ff @(posedge clk) begin
      if (reset) begin
         stat_q <= ras_pkg::STAT_RESET;
         fault_reset_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         fault_reset_q <= fault;
      end
   end

   assign fault_reset = fault_reset_q;
   assign irq = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   AST_PUSH_INC: assert property (@(posedge clk) disable iff (reset)
      core_push && stack_pointer_q < ras_pkg::PTR_LAST
      |=> stack_pointer_q == $past(stack_pointer_q) + 5'h01)
      else $error("push did not advance the pointer by one");

   AST_POP_DEC: assert property (@(posedge clk) disable iff (reset)
      core_pop && !core_push && stack_pointer_q <= ras_pkg::PTR_LAST
      && stack_pointer_q != ras_pkg::PTR_FIRST
      |=> stack_pointer_q == $past(stack_pointer_q) - 5'h01)
      else $error("pop did not lower the pointer by one");

   AST_PUSH_STORE: assert property (@(posedge clk) disable iff (reset)
      core_push && !fault |=> top_entry == $past(core_push_pc))
      else $error("pushed pc not at the new top");

   // helper: the last pushed pc is still on top until a pop or a software write
   logic pushed_last_q;
   logic [14:0] last_push_pc_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         pushed_last_q <= 1'b0;
         last_push_pc_q <= 15'h0000;
      end else begin
         pushed_last_q <= push ? !fault : (pushed_last_q && !pop && !wr_q);
         if (push) begin
            last_push_pc_q <= core_push_pc;
         end
      end
   end

   AST_PUSH_POP: assert property (@(posedge clk) disable iff (reset)
      pop && pushed_last_q |-> core_pop_pc == last_push_pc_q)
      else $error("pop did not return the last pushed pc");

   AST_OVF_FLAG: assert property (@(posedge clk) disable iff (reset)
      core_push && stack_pointer_q == ras_pkg::PTR_LAST
      |=> stat_q[ras_pkg::STAT_OVF] ##1 stat_q[ras_pkg::STAT_OVF]
          || $past(wr_q))
      else $error("overflow flag not set");

   AST_UNF_FLAG: assert property (@(posedge clk) disable iff (reset)
      core_pop && !core_push && stack_pointer_q == ras_pkg::PTR_EMPTY
      |=> stat_q[ras_pkg::STAT_UNF])
      else $error("underflow flag not set");

   AST_WRAP: assert property (@(posedge clk) disable iff (reset)
      core_push && stack_pointer_q == ras_pkg::PTR_LAST && !fault_rst_en_q
      |=> stack_pointer_q == ras_pkg::PTR_FIRST && !fault_reset)
      else $error("seventeenth push did not wrap to the first entry");

   AST_FAULT_RST: assert property (@(posedge clk) disable iff (reset)
      (ovf || unf) && fault_rst_en_q
      |=> fault_reset && stack_pointer_q == ras_pkg::PTR_EMPTY
          && (stat_q[ras_pkg::STAT_OVF] || stat_q[ras_pkg::STAT_UNF]))
      else $error("enabled fault gave no reset pulse");

   AST_PTR_RANGE: assert property (@(posedge clk) disable iff (reset)
      (push || pop) && !fault
      && (stack_pointer_q <= ras_pkg::PTR_LAST || stack_pointer_q == ras_pkg::PTR_EMPTY)
      |=> stack_pointer_q <= ras_pkg::PTR_LAST || stack_pointer_q == ras_pkg::PTR_EMPTY)
      else $error("pointer outside the entry range");

   AST_SW_LOW: assert property (@(posedge clk) disable iff (reset)
      wr_low && !core_push && !core_pop
      |=> top_entry[7:0] == $past(hwdata[7:0]) || $past(stack_pointer_q) != stack_pointer_q)
      else $error("software write to the low top byte lost");
endmodule // ras_top
`default_nettype wire

// ---- verification/ras_core_model.sv ----
// core sequencer model: issues pushes and pops to the stack
`timescale 1ns/1ns
`default_nettype none
module ras_core_model (
   input wire logic clk,
   output logic core_push,
   output logic [14:0] core_push_pc,
   output logic core_pop,
   input wire logic [14:0] core_pop_pc
);
   initial begin
      core_push = 1'b0;
      core_push_pc = 15'h0;
      core_pop = 1'b0;
   end
   ////////////////////////////////////////
   // call, call via working reg or interrupt vectoring
   task automatic push(input logic [14:0] pc);
      @(posedge clk);
      core_push <= 1'b1;
      core_push_pc <= pc;
      @(posedge clk);
      core_push <= 1'b0;
      // released data must not look valid
      core_push_pc <= ~pc;
   endtask
   // any return kind; pc taken at the edge that pops, before the pointer moves
   task automatic pop(output logic [14:0] pc);
      @(posedge clk);
      core_pop <= 1'b1;
      @(posedge clk);
      pc = core_pop_pc;
      core_pop <= 1'b0;
   endtask
endmodule // ras_core_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the return address stack
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic core_push, core_pop, fault_reset, irq, hready, hreadyout, hresp;
   logic [14:0] core_push_pc, core_pop_pc, pc;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   int n_errors = 0;
   int total_checks = 0;
   int n_fault = 0;
   always #2 clk = ~clk;
   assign hready = hreadyout;
   // counts cycles high, so a long pulse shows as an extra count
   always @(posedge clk) if (fault_reset === 1'b1) n_fault <= n_fault + 1;
   ras_top i_ras_top (.clk(clk), .reset(reset), .core_push(core_push),
      .core_push_pc(core_push_pc), .core_pop(core_pop), .core_pop_pc(core_pop_pc),
      .fault_reset(fault_reset), .irq(irq), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   ras_core_model m_core (.clk(clk), .core_push(core_push),
      .core_push_pc(core_push_pc), .core_pop(core_pop), .core_pop_pc(core_pop_pc));
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // a wait ends once hready is high; only the watchdog ends a stuck one
   task automatic wait_rdy();
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
   endtask
   task automatic rg(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string msg);
      rg(1'b0, a, 32'h0);
      check(rd, exp, msg);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rc(ras_pkg::OFF_POINTER, 32'h1f, "ptr rst");
      rc(ras_pkg::OFF_CTRL, 32'h0, "ctrl rst");
      rc(ras_pkg::OFF_STATUS, 32'h0, "stat rst");
      rc(ras_pkg::OFF_MASK, 32'h0, "mask rst");
      rg(1'b1, 8'h18, 32'hffffffff);
      rc(8'h18, 32'h0, "unmapped");
      check({31'h0, irq}, 32'h0, "irq rst");
      check({30'h0, hreadyout, hresp}, 32'h2, "bus answer");
      $display("test reset done");
   endtask
   task automatic t_lifo();
      logic [14:0] v[3] = '{15'h1234, 15'h0567, 15'h7abc};
      for (int i = 0; i < 3; i++) m_core.push(v[i]);
      rc(ras_pkg::OFF_POINTER, 32'h2, "ptr 3 calls");
      rc(ras_pkg::OFF_TOP_LOW, 32'hbc, "top low");
      rc(ras_pkg::OFF_TOP_HIGH, 32'h7a, "top high");
      for (int i = 2; i >= 0; i--) begin
         m_core.pop(pc);
         check({17'h0, pc}, {17'h0, v[i]}, "pop order");
      end
      rc(ras_pkg::OFF_POINTER, 32'h1f, "ptr empty");
      $display("test lifo done");
   endtask
   task automatic t_sw();
      m_core.push(15'h0a0a);
      m_core.push(15'h0b0b);
      // core idle while software moves the pointer
      rg(1'b1, ras_pkg::OFF_POINTER, 32'h0);
      rc(ras_pkg::OFF_TOP_LOW, 32'h0a, "sel low");
      rc(ras_pkg::OFF_TOP_HIGH, 32'h0a, "sel high");
      rg(1'b1, ras_pkg::OFF_TOP_LOW, 32'h55);
      rg(1'b1, ras_pkg::OFF_TOP_HIGH, 32'h2a);
      rg(1'b1, ras_pkg::OFF_POINTER, 32'hff);
      rc(ras_pkg::OFF_POINTER, 32'h1f, "ptr width");
      rg(1'b1, ras_pkg::OFF_POINTER, 32'h1);
      m_core.pop(pc);
      check({17'h0, pc}, 32'h0b0b, "pop b");
      m_core.pop(pc);
      check({17'h0, pc}, 32'h2a55, "sw written");
      $display("test software access done");
   endtask
   task automatic t_wrap();
      rg(1'b1, ras_pkg::OFF_MASK, 32'h1);
      for (int i = 0; i < 16; i++) m_core.push(15'h0100 + 15'(i));
      rc(ras_pkg::OFF_STATUS, 32'h0, "full no ovf");
      rc(ras_pkg::OFF_MASK, 32'h1, "mask kept");
      check({31'h0, irq}, 32'h0, "irq idle");
      m_core.push(15'h7777);
      rc(ras_pkg::OFF_STATUS, 32'h1, "ovf flag");
      check({31'h0, irq}, 32'h1, "irq ovf");
      rc(ras_pkg::OFF_POINTER, 32'h0, "wrap ptr");
      m_core.pop(pc);
      check({17'h0, pc}, 32'h7777, "wrap entry");
      // underflow here: entry 15 still holds the sixteenth push
      m_core.pop(pc);
      check({17'h0, pc}, 32'h010f, "entry 15");
      rc(ras_pkg::OFF_POINTER, 32'hf, "unf wrap");
      rc(ras_pkg::OFF_STATUS, 32'h3, "unf flag");
      check(32'(n_fault), 32'h0, "no fault");
      rg(1'b1, ras_pkg::OFF_STATUS, 32'h3);
      rc(ras_pkg::OFF_STATUS, 32'h0, "w1c");
      check({31'h0, irq}, 32'h0, "irq clr");
      $display("test wrap done");
   endtask
   task automatic t_fault();
      rg(1'b1, ras_pkg::OFF_CTRL, 32'h1);
      rg(1'b1, ras_pkg::OFF_MASK, 32'h2);
      rg(1'b1, ras_pkg::OFF_POINTER, 32'h1f);
      m_core.pop(pc);
      rc(ras_pkg::OFF_POINTER, 32'h1f, "unf ptr");
      rc(ras_pkg::OFF_STATUS, 32'h2, "unf kept");
      check(32'(n_fault), 32'h1, "unf pulse");
      check({31'h0, irq}, 32'h1, "irq unf");
      rg(1'b1, ras_pkg::OFF_POINTER, 32'hf);
      m_core.push(15'h1111);
      rc(ras_pkg::OFF_POINTER, 32'h1f, "ovf ptr");
      rc(ras_pkg::OFF_STATUS, 32'h3, "ovf kept");
      check(32'(n_fault), 32'h2, "ovf pulse");
      $display("test fault reset done");
   endtask
   ////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_lifo();
      t_sw();
      t_wrap();
      t_fault();
      print_verdict();
   end
   // tests need well under 2000 cycles
   initial begin
      #200000;
      n_errors++;
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
